// file: hdl/plm_regs.svh
// Constants of the programmable logic macrocell block: sizes, offsets, fields.
// Assumes inclusion by the package and the design files through its bare name.
`ifndef PLM_REGS_SVH
`define PLM_REGS_SVH

// ****************************************************************
// Array geometry
// ****************************************************************
`define PLM_NUM_IN      12
`define PLM_NUM_MC      10
`define PLM_NUM_SIG     22
`define PLM_NUM_COL     44
`define PLM_NUM_SUM     120
`define PLM_OE_BASE     120
`define PLM_AR_TERM     130
`define PLM_SS_TERM     131
`define PLM_NUM_TERM    132
`define PLM_MIN_TERMS   8
`define PLM_TERM_STEP   2
`define PLM_HALF_MC     5

// ****************************************************************
// Register map, byte addresses
// ****************************************************************
`define PLM_ADR_W       12
`define PLM_ADR_STATUS  12'h000
`define PLM_ADR_PRELOAD 12'h004
`define PLM_ADR_MCFG    12'h008
`define PLM_ADR_SECURE  12'h00C
`define PLM_ARRAY_SEL   2'h1

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PLM_HI_LSB      16
`define PLM_FUSE_HI_W   12
`define PLM_PIN_RST     10'h3FF
`define PLM_OEN_RST     10'h3FF

`endif

// file: hdl/plm_pkg.sv
// Types shared by the programmable logic macrocell block.
// Assumes plm_regs.svh is on the include path.
`include "plm_regs.svh"

package plm_pkg;

    // Classic Wishbone request from the master.
    typedef struct packed {
        logic                  cyc;
        logic                  stb;
        logic                  we;
        logic [`PLM_ADR_W-1:0] adr;
        logic [3:0]            sel;
        logic [31:0]           dat;
    } plm_wb_req_t;

    // Select fuses of one macrocell.
    typedef struct packed {
        logic fbMode;
        logic pol;
    } plm_mc_cfg_t;

    // Shared controls that reach one macrocell.
    typedef struct packed {
        logic asyncClr;
        logic syncSet;
        logic clkRise;
        logic preload;
        logic preVal;
    } plm_mc_ctl_t;

    // Whole state of the top module.
    typedef struct packed {
        logic [`PLM_NUM_TERM-1:0][`PLM_NUM_COL-1:0] fuse;
        logic [`PLM_NUM_MC-1:0]                     fbMode;
        logic [`PLM_NUM_MC-1:0]                     pol;
        logic                                       secured;
        logic [`PLM_NUM_MC-1:0]                     mcReg;
        logic                                       clkPrev;
        logic [`PLM_NUM_MC-1:0]                     pinOut;
        logic [`PLM_NUM_MC-1:0]                     pinOeN;
        logic                                       ack;
        logic [31:0]                                rdat;
    } plm_state_t;

endpackage

// file: hdl/plm_macrocell.sv
// One output logic macrocell: OR gate, register next value, pin and feedback.
// Assumes the top module registers regD, pinD and oeND; feedback goes to the array unregistered.
`timescale 1ns/1ps

module plm_macrocell
    import plm_pkg::*;
#(
    parameter int NTERMS = 8
) (
    // Product terms from the array.
    input  wire logic [NTERMS-1:0] sumTerms,
    input  wire logic              oeTerm,
    // Fuses and shared controls.
    input  wire plm_mc_cfg_t       cfg,
    input  wire plm_mc_ctl_t       ctl,
    // Present register and pin levels.
    input  wire logic              regQ,
    input  wire logic              pinIn,
    // Next values and array feedback.
    output logic                   regD,
    output logic                   pinD,
    output logic                   oeND,
    output logic                   feedback
);

    logic sum;

    always_comb begin
        sum = |sumTerms;
        // Clear outranks everything, so a stuck reset term cannot be fought by a preload.
        if (ctl.asyncClr) begin
            regD = 1'b0;
        end else if (ctl.preload) begin
            regD = ctl.preVal;
        end else if (ctl.clkRise) begin
            regD = ctl.syncSet ? 1'b1 : sum;
        end else begin
            regD = regQ;
        end
        feedback = cfg.fbMode ? pinIn : regQ;
        if (cfg.fbMode) begin
            pinD = ~(sum ^ cfg.pol);
        end else begin
            pinD = ~(regD ^ cfg.pol);
        end
        oeND = ~oeTerm;
    end

endmodule // plm_macrocell

// file: hdl/plm_top.sv
// Programmable AND-OR array with ten output macrocells, fuses held in registers.
// Assumes a classic Wishbone master and board inputs synchronous to clock.
//
// Summary of operation
// - Twelve dedicated inputs plus ten feedbacks feed the array; ten outputs.
// - Each output enable comes from its own product term.
// - Outputs receive 8,10,12,14,16,16,14,12,10,8 product terms.
// - Set term true loads one into all registers at device clock rise.
// - Reset term true clears all registers without waiting for device clock.
// - One set term and one reset term serve all registers together.
// - Pin level after set or reset follows the programmed polarity.
// - Test preload writes any chosen state into the registers.
// - Any pin can feed the array as an input when used so.
// - At power-up registers clear; active-low pins high, active-high low.
// - Security fuse blocks fuse readback; all fuses then read open.
// - Feedback fuse: 0 registered, 1 combinational; polarity fuse: 0 low, 1 high.
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "plm_regs.svh"

module plm_top
    import plm_pkg::*;
(
    // System.
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // Wishbone slave.
    input  wire plm_wb_req_t            wbReq,
    output logic                        wbAck,
    output logic [31:0]                 wbDat,
    // Board inputs.
    input  wire logic                   devClk,
    input  wire logic [`PLM_NUM_IN-1:0] devIn,
    // I/O pins.
    input  wire logic [`PLM_NUM_MC-1:0] ioIn,
    output logic      [`PLM_NUM_MC-1:0] ioOut,
    output logic      [`PLM_NUM_MC-1:0] ioOeN
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    plm_state_t                st_q;
    plm_state_t                st_d;
    logic [`PLM_NUM_SIG-1:0]   arraySig;
    logic [`PLM_NUM_COL-1:0]   cols;
    logic [`PLM_NUM_TERM-1:0]  terms;
    logic [`PLM_NUM_MC-1:0]    fb;
    logic [`PLM_NUM_MC-1:0]    regD;
    logic [`PLM_NUM_MC-1:0]    pinD;
    logic [`PLM_NUM_MC-1:0]    oeND;
    logic [`PLM_NUM_MC-1:0]    preVal;
    logic [`PLM_NUM_MC-1:0]    preMask;
    logic                      clkRise;
    logic                      arTerm;
    logic                      ssTerm;
    logic                      busReq;
    logic                      isArray;
    logic                      arrayHit;
    logic                      preloadHit;
    logic                      fuseRead;
    logic [`PLM_ADR_W-1:0]     arrayOff;
    logic [7:0]                termIdx;
    logic                      wordHi;
    logic [31:0]               hiMerged;

    function automatic int termCount(input int idx);
        int d;
        d = (idx < `PLM_HALF_MC) ? idx : (`PLM_NUM_MC - 1 - idx);
        return `PLM_MIN_TERMS + `PLM_TERM_STEP * d;
    endfunction

    // Terms are packed from output 0 upward, so an output starts after all the shares before it.
    function automatic int termBase(input int idx);
        int acc;
        acc = 0;
        for (int k = 0; k < idx; k++) begin
            acc += termCount(k);
        end
        return acc;
    endfunction

    // Byte lanes follow sel so software may patch one byte of a term.
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) begin
            m[8*b +: 8] = {8{sel[b]}};
        end
        return (old & ~m) | (nw & m);
    endfunction

    // ****************************************************************
    // AND array
    // ****************************************************************
    assign arraySig = {fb, devIn};
    // The device clock is sampled, so a rise acts one system clock after it is seen.
    // A device clock faster than half the system clock would lose edges.
    assign clkRise  = devClk & ~st_q.clkPrev;

    // A fuse bit of 1 is blown and disconnects its column from the term.
    always_comb begin
        for (int k = 0; k < `PLM_NUM_SIG; k++) begin
            cols[2*k]   = arraySig[k];
            cols[2*k+1] = ~arraySig[k];
        end
        for (int t = 0; t < `PLM_NUM_TERM; t++) begin
            terms[t] = &(cols | st_q.fuse[t]);
        end
    end

    assign arTerm = terms[`PLM_AR_TERM];
    assign ssTerm = terms[`PLM_SS_TERM];

    // ****************************************************************
    // Macrocells
    // ****************************************************************
    // Every macrocell sees the same reset, set and clock controls; only preload is masked.
    for (genvar i = 0; i < `PLM_NUM_MC; i++) begin : g_mc
        localparam int NT   = termCount(i);
        localparam int BASE = termBase(i);
        plm_mc_cfg_t cfg;
        plm_mc_ctl_t ctl;
        assign cfg.fbMode   = st_q.fbMode[i];
        assign cfg.pol      = st_q.pol[i];
        assign ctl.asyncClr = arTerm;
        assign ctl.syncSet  = ssTerm;
        assign ctl.clkRise  = clkRise;
        assign ctl.preload  = preloadHit & preMask[i];
        assign ctl.preVal   = preVal[i];
        plm_macrocell #(
            .NTERMS(NT)
        ) u_mc (
            .sumTerms(terms[BASE +: NT]),
            .oeTerm  (terms[`PLM_OE_BASE + i]),
            .cfg     (cfg),
            .ctl     (ctl),
            .regQ    (st_q.mcReg[i]),
            .pinIn   (ioIn[i]),
            .regD    (regD[i]),
            .pinD    (pinD[i]),
            .oeND    (oeND[i]),
            .feedback(fb[i])
        );
    end

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign busReq     = wbReq.cyc & wbReq.stb & ~st_q.ack;
    // The array holds more terms than fit below the next address block,
    // so the term index needs eight bits counted from the array base.
    assign arrayOff   = wbReq.adr - {`PLM_ARRAY_SEL, 10'h000};
    assign termIdx    = arrayOff[10:3];
    assign wordHi     = wbReq.adr[2];
    assign isArray    = ~arrayOff[11];
    assign arrayHit   = isArray && (termIdx < 8'(`PLM_NUM_TERM));
    assign preloadHit = busReq & wbReq.we & (wbReq.adr == `PLM_ADR_PRELOAD);
    assign preVal     = wbReq.dat[`PLM_NUM_MC-1:0];
    assign preMask    = wbReq.dat[`PLM_HI_LSB +: `PLM_NUM_MC];
    assign fuseRead   = busReq & ~wbReq.we & (arrayHit | (wbReq.adr == `PLM_ADR_MCFG));
    // The high word keeps only twelve columns; merging a full word keeps the lanes simple.
    assign hiMerged   = mergeBytes({20'h0, st_q.fuse[termIdx][`PLM_NUM_COL-1:32]},
                                   wbReq.dat, wbReq.sel);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d         = st_q;
        st_d.ack     = busReq;
        st_d.clkPrev = devClk;
        st_d.mcReg   = regD;
        st_d.pinOut  = pinD;
        st_d.pinOeN  = oeND;
        st_d.rdat    = 32'h0;
        if (busReq && wbReq.we) begin
            if (arrayHit && !wordHi) begin
                st_d.fuse[termIdx][31:0] =
                    mergeBytes(st_q.fuse[termIdx][31:0], wbReq.dat, wbReq.sel);
            end else if (arrayHit) begin
                st_d.fuse[termIdx][`PLM_NUM_COL-1:32] = hiMerged[`PLM_FUSE_HI_W-1:0];
            end else if (wbReq.adr == `PLM_ADR_MCFG) begin
                st_d.fbMode = wbReq.dat[`PLM_NUM_MC-1:0];
                st_d.pol    = wbReq.dat[`PLM_HI_LSB +: `PLM_NUM_MC];
            end else if (wbReq.adr == `PLM_ADR_SECURE) begin
                // Once blown the security fuse cannot be restored by any write; only reset clears it.
                st_d.secured = st_q.secured | wbReq.dat[0];
            end
        end
        if (busReq && !wbReq.we) begin
            if (fuseRead && st_q.secured) begin
                st_d.rdat = 32'hFFFFFFFF;
            end else if (arrayHit && !wordHi) begin
                st_d.rdat = st_q.fuse[termIdx][31:0];
            end else if (arrayHit) begin
                st_d.rdat = {20'h0, st_q.fuse[termIdx][`PLM_NUM_COL-1:32]};
            end else begin
                case (wbReq.adr)
                    `PLM_ADR_STATUS: begin
                        st_d.rdat = {6'h0, st_q.pinOeN, 6'h0, st_q.pinOut};
                    end
                    `PLM_ADR_PRELOAD: begin
                        st_d.rdat = {22'h0, st_q.mcReg};
                    end
                    `PLM_ADR_MCFG: begin
                        st_d.rdat = {6'h0, st_q.pol, 6'h0, st_q.fbMode};
                    end
                    `PLM_ADR_SECURE: begin
                        st_d.rdat = {31'h0, st_q.secured};
                    end
                    default: begin
                        st_d.rdat = 32'h0;
                    end
                endcase
            end
        end
        // Reset clears every register, fuses included, but loads pinOut and pinOeN with all ones, so pins sit high and released.
        if (!rstn) begin
            st_d        = '0;
            st_d.pinOut = `PLM_PIN_RST;
            st_d.pinOeN = `PLM_OEN_RST;
        end
    end

    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign wbAck = st_q.ack;
    assign wbDat = st_q.rdat;
    assign ioOut = st_q.pinOut;
    assign ioOeN = st_q.pinOeN;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cbChk @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence sHoldCause;
        !arTerm && !clkRise && !preloadHit;
    endsequence

    sequence sSetCause;
        ssTerm && clkRise && !arTerm && !preloadHit;
    endsequence

    sequence sCfgWrite;
        busReq && wbReq.we && (wbReq.adr == `PLM_ADR_MCFG);
    endsequence

    chk_async_clear: assert property (arTerm |=> st_q.mcReg == '0)
        else $error("reset term did not clear the registers");
    chk_sync_set_all: assert property (sSetCause |=> &st_q.mcReg)
        else $error("set term did not load ones");
    chk_hold_no_edge: assert property (sHoldCause |=> $stable(st_q.mcReg))
        else $error("register changed without a device clock rise");
    chk_pin_polarity: assert property (
        $stable(st_q.pol) && $stable(st_q.fbMode) |->
        ((st_q.pinOut ^ ~(st_q.mcReg ^ st_q.pol)) & ~st_q.fbMode) == '0)
        else $error("registered pin level does not match polarity");
    chk_oe_term_map: assert property (
        1'b1 |=> st_q.pinOeN == ~$past(terms[`PLM_NUM_TERM-3:`PLM_OE_BASE]))
        else $error("output enable does not follow its term");
    chk_preload_state: assert property (
        preloadHit && !arTerm |=> ((st_q.mcReg ^ $past(preVal)) & $past(preMask)) == '0)
        else $error("preload value not loaded");
    chk_powerup_clear: assert property (
        $rose(rstn) |-> st_q.mcReg == '0 && st_q.pinOut == `PLM_PIN_RST)
        else $error("registers not cleared after reset");
    chk_secure_sticky: assert property (st_q.secured |=> st_q.secured)
        else $error("security fuse restored");
    chk_secure_read_open: assert property (
        fuseRead && st_q.secured |=> st_q.ack && st_q.rdat == 32'hFFFFFFFF)
        else $error("fuse readback not blocked");
    chk_ack_single: assert property (st_q.ack |=> !st_q.ack)
        else $error("ack held beyond one cycle");

    // ****************************************************************
    // Bus and pin level checks
    // ****************************************************************
    chk_ack_after_req: assert property (busReq |=> st_q.ack)
        else $error("request not answered in one cycle");
    chk_rdat_idle: assert property (!st_q.ack |-> st_q.rdat == '0)
        else $error("read data not zero outside ack");
    chk_cfg_write: assert property (
        sCfgWrite |=> st_q.fbMode == $past(wbReq.dat[`PLM_NUM_MC-1:0]) &&
        st_q.pol == $past(wbReq.dat[`PLM_HI_LSB +: `PLM_NUM_MC]))
        else $error("select fuses not written");
    chk_set_pins: assert property (
        sSetCause |=> ((st_q.pinOut ^ $past(st_q.pol)) & ~$past(st_q.fbMode)) == '0)
        else $error("pin level after set ignores polarity");
    chk_clear_pins: assert property (
        arTerm |=> ((st_q.pinOut ^ ~$past(st_q.pol)) & ~$past(st_q.fbMode)) == '0)
        else $error("pin level after reset ignores polarity");

endmodule // plm_top

// file: tb/plm_board.sv
// Board model: drives the device clock and loops driven pins back to their inputs.
// Assumes the bench calls pulse only after reset has been released.
`timescale 1ns/1ps
`include "plm_regs.svh"

module plm_board
    import plm_pkg::*;
(
    // System.
    input  wire logic                   clock,
    // Pins of the block.
    input  wire logic [`PLM_NUM_MC-1:0] ioOut,
    input  wire logic [`PLM_NUM_MC-1:0] ioOeN,
    // Levels that other board parts put on released pins.
    input  wire logic [`PLM_NUM_MC-1:0] extIn,
    output logic                        devClk,
    output logic      [`PLM_NUM_MC-1:0] ioIn
);
    initial devClk = 1'b0;

    // A pin that the block drives shows its own level; a released pin shows the board.
    always_comb begin
        for (int i = 0; i < `PLM_NUM_MC; i++) begin
            ioIn[i] = ioOeN[i] ? extIn[i] : ioOut[i];
        end
    end

    // The clock stays low between pulses, and no rise comes until the bench asks for one,
    // so all inputs have settled for at least one system clock before every rise.
    task automatic pulse;
        @(posedge clock);
        devClk <= 1'b1;
        repeat (2) @(posedge clock);
        devClk <= 1'b0;
        repeat (2) @(posedge clock);
    endtask
endmodule // plm_board

// file: tb/tb_plm_top.sv
// Self-checking bench for the macrocell array, driven through Wishbone and board pins.
// Assumes plm_top and plm_board are compiled before it.
`timescale 1ns/1ps
`include "plm_regs.svh"

module tb_plm_top;
    import plm_pkg::*;

    logic                   clock;
    logic                   rstn;
    plm_wb_req_t            wbReq;
    logic                   wbAck;
    logic [31:0]            wbDat;
    logic                   devClk;
    logic [`PLM_NUM_IN-1:0] devIn;
    logic [`PLM_NUM_MC-1:0] ioIn;
    logic [`PLM_NUM_MC-1:0] ioOut;
    logic [`PLM_NUM_MC-1:0] ioOeN;
    logic [`PLM_NUM_MC-1:0] extIn;
    int                     fails;
    int                     n_compared;
    int                     lastTerm [10] = '{7, 17, 29, 43, 59, 75, 89, 101, 111, 119};

    always #2 clock = ~clock;

    plm_top u_plm_top (.clock(clock), .rstn(rstn), .wbReq(wbReq), .wbAck(wbAck),
        .wbDat(wbDat), .devClk(devClk), .devIn(devIn), .ioIn(ioIn), .ioOut(ioOut),
        .ioOeN(ioOeN));

    plm_board u_plm_board (.clock(clock), .ioOut(ioOut), .ioOeN(ioOeN), .extIn(extIn),
        .devClk(devClk), .ioIn(ioIn));

    // ****************************************************************
    // Checking and bus tasks
    // ****************************************************************
    task automatic final_report;
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; read data is taken at the edge where ack is seen high.
    task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        n = 0;
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDat;
        wbReq <= '0;
        if (n >= 20) begin
            fails++;
            $display("CHECK FAILED wb ack expected 1 seen 0");
            final_report();
        end
        @(posedge clock);
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] d);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, d, rd);
    endtask

    task automatic rd_chk(input string name, input logic [11:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 32'h0, rd);
        chk(name, exp, rd);
    endtask

    // A blown column is ignored, so an all-blown term is always true.
    task automatic term(input int t, input logic [31:0] lo, input logic [11:0] hi);
        wr(12'h400 + 12'(8 * t), lo);
        wr(12'h404 + 12'(8 * t), {20'h0, hi});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        clock = 1'b0;
        rstn = 1'b0;
        wbReq = '0;
        devIn = '0;
        extIn = '0;
        fails = 0;
        n_compared = 0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd_chk("status", `PLM_ADR_STATUS, 32'h03FF03FF);
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h0);
        wr(`PLM_ADR_MCFG, 32'h03FF0000);
        rd_chk("mcfg", `PLM_ADR_MCFG, 32'h03FF0000);
        rd_chk("status", `PLM_ADR_STATUS, 32'h03FF0000);
        term(120, 32'hFFFFFFFF, 12'hFFF);
        rd_chk("status", `PLM_ADR_STATUS, 32'h03FE0000);
        chk("oe pins", 32'h3FE, {22'h0, ioOeN});
        term(131, 32'hFFFFFFFF, 12'hFFF);
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h0);
        u_plm_board.pulse();
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h3FF);
        rd_chk("status", `PLM_ADR_STATUS, 32'h03FE03FF);
        term(131, 32'h0, 12'h0);
        term(130, 32'hFFFFFFFF, 12'hFFF);
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h0);
        term(130, 32'h0, 12'h0);
        wr(`PLM_ADR_PRELOAD, 32'h03FF0155);
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h155);
        rd_chk("status", `PLM_ADR_STATUS, 32'h03FE0155);
        // The last term of each output proves where its share of terms ends.
        for (int i = 0; i < 10; i++) begin
            term(lastTerm[i], 32'hFFFFFFFF, 12'hFFF);
            u_plm_board.pulse();
            rd_chk("regs", `PLM_ADR_PRELOAD, 32'h1 << i);
            term(lastTerm[i], 32'h0, 12'h0);
        end
        // Highest dedicated input and highest register feedback reach the array.
        wr(`PLM_ADR_PRELOAD, 32'h03FF0200);
        term(0, 32'hFFBFFFFF, 12'hFFF);
        term(8, 32'hFFFFFFFF, 12'hBFF);
        devIn <= 12'h800;
        u_plm_board.pulse();
        rd_chk("regs", `PLM_ADR_PRELOAD, 32'h003);
        term(0, 32'h0, 12'h0);
        term(8, 32'h0, 12'h0);
        // Pin 0 released and used as an input to combinational output 2.
        term(120, 32'h0, 12'h0);
        wr(`PLM_ADR_MCFG, 32'h03FF0005);
        term(18, 32'hFEFFFFFF, 12'hFFF);
        for (int v = 0; v < 4; v++) begin
            if (v == 2) begin
                wr(`PLM_ADR_MCFG, 32'h03FB0005);
            end
            extIn <= {9'h0, v[0]};
            repeat (3) @(posedge clock);
            chk("pin2", {31'h0, v[0] ^ (v < 2 ? 1'b0 : 1'b1)}, {31'h0, ioOut[2]});
        end
        wr(`PLM_ADR_SECURE, 32'h1);
        rd_chk("mcfg", `PLM_ADR_MCFG, 32'hFFFFFFFF);
        rd_chk("fuse", 12'h400, 32'hFFFFFFFF);
        rd_chk("unmapped", 12'h100, 32'h0);
        final_report();
    end
endmodule // tb_plm_top
